// File: bench/hpm_assertions.sv
// Purpose: Link protocol and mode-write checks between the two ends
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only hpm_link_if signals
`timescale 1ns/100ps
`include "hpm_cfg.svh"
module hpm_assertions #(
  parameter int READY_CYC = `HPM_POWERUP_CYC
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       reg_req,
  input wire logic       reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic       en_pin,
  input wire logic       in_pin,
  input wire logic [7:0] analog_lvl
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Saturating count of cycles since reset
  int ready_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ready_cnt_q <= 0;
    else if (ready_cnt_q < READY_CYC) ready_cnt_q <= ready_cnt_q + 1;
  end
  wire take     = reg_req & ~reg_ack;
  wire mode_wr  = reg_req & reg_we & (reg_addr == `HPM_REG_MODE);
  wire play_val = (reg_wdata[2:0] <= 3'h3) | (reg_wdata[2:0] == 3'h5);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_after_take: assert property (take |=> reg_ack)
    else $error("link ack not one cycle after take");
  a_ack_single: assert property (reg_ack |=> !reg_ack)
    else $error("link ack longer than one cycle");
  a_req_held: assert property (take |=> reg_req && $stable(reg_we) && $stable(reg_addr)
    && $stable(reg_wdata))
    else $error("link request changed before ack");
  a_req_release: assert property (reg_ack |=> !reg_req)
    else $error("link request not dropped after ack");
  a_ack_cause: assert property ($rose(reg_ack) |-> $past(take))
    else $error("link ack without request");
  a_rdata_hold: assert property (!reg_ack && !$past(sys_rst) |-> $stable(reg_rdata))
    else $error("link read data moved without ack");
  a_startup_quiet: assert property ((ready_cnt_q + 2) < READY_CYC |-> !reg_req)
    else $error("link request before start-up wait");
  a_mode_standby: assert property (mode_wr && play_val |-> !reg_wdata[`HPM_STANDBY_BIT])
    else $error("playback mode written with standby set");
  a_en_on_mode: assert property (mode_wr && play_val && reg_ack |-> en_pin)
    else $error("playback mode written with enable low");
endmodule // hpm_assertions

// File: bench/tb_haptic_playback_mode_control.sv
// Purpose: AXI-driven bench of controller and device joined by the link
// Assumes: READY_CYC shortened; PWM period at its default
// Notes:   Device register accesses go through CMD and STAT
`timescale 1ns/100ps
`include "hpm_cfg.svh"
module tb_haptic_playback_mode_control
  import hpm_pkg::*;
;
  localparam int READY_SIM = 20;
  localparam int LIMIT     = 40000;
  logic        sys_clk, sys_rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  drive_amp_q;
  logic        low_power_q, effect_fire_q;
  logic [2:0]  mode_q;
  logic [6:0]  effect_index_q;
  int          error_cnt, tests_run, cyc_cnt, fire_cnt;
  hpm_link_if u_hpm_link_if ();
  hpm_host #(.READY_CYC(READY_SIM)) u_hpm_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lnk(u_hpm_link_if));
  hpm_dev u_hpm_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(u_hpm_link_if),
    .drive_amp_q(drive_amp_q), .low_power_q(low_power_q), .mode_q(mode_q),
    .effect_index_q(effect_index_q), .effect_fire_q(effect_fire_q));
  hpm_assertions #(.READY_CYC(READY_SIM)) u_hpm_assertions (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_req(u_hpm_link_if.reg_req), .reg_we(u_hpm_link_if.reg_we),
    .reg_addr(u_hpm_link_if.reg_addr), .reg_wdata(u_hpm_link_if.reg_wdata),
    .reg_ack(u_hpm_link_if.reg_ack), .reg_rdata(u_hpm_link_if.reg_rdata),
    .en_pin(u_hpm_link_if.en_pin), .in_pin(u_hpm_link_if.in_pin),
    .analog_lvl(u_hpm_link_if.analog_lvl));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog and fire pulse counter
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (effect_fire_q === 1'b1) fire_cnt++;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Both channels offered together; bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    // One edge between transfers so bready is never driven twice in a step
    @(posedge sys_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", er, s_axi_rresp);
    @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    do axi_rd(`HPM_HREG_STAT, s, 2'b00); while (s[`HPM_STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic dev_wr(input hpm_byte_t a, input hpm_byte_t d);
    axi_wr(`HPM_HREG_CMD, {15'h0000, 1'b1, a, d}, 2'b00);
    wait_idle();
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic dev_rd(input hpm_byte_t a, input hpm_byte_t exp);
    logic [31:0] s;
    axi_wr(`HPM_HREG_CMD, {15'h0000, 1'b0, a, 8'h00}, 2'b00);
    wait_idle();
    axi_rd(`HPM_HREG_STAT, s, 2'b00);
    chk("dev_rd", exp, s[15:8]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int f0;
    sys_rst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    fire_cnt = 0;
    repeat (2) @(posedge sys_clk);
    chk("rst_low_power", 1'b1, low_power_q);
    chk("rst_index", 7'h00, effect_index_q);
    sys_rst <= 1'b0;
    do axi_rd(`HPM_HREG_STAT, d, 2'b00); while (d[`HPM_STAT_READY_BIT] !== 1'b1);
    dev_rd(`HPM_REG_MODE, `HPM_MODE_RST);
    dev_rd(`HPM_REG_RTP, `HPM_RTP_RST);
    dev_rd(`HPM_REG_CTL3, `HPM_CTL3_RST);
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0001, 2'b00);
    dev_wr(`HPM_REG_MODE, 8'h05);
    chk("mode_rt", `HPM_MODE_REALTIME, mode_q);
    chk("awake", 1'b0, low_power_q);
    dev_wr(`HPM_REG_MODE, 8'h05);
    axi_rd(`HPM_HREG_STAT, d, 2'b00);
    chk("skip", 1'b1, d[`HPM_STAT_SKIP_BIT]);
    dev_wr(`HPM_REG_RTP, 8'h7f);
    chk("amp_7f", 8'h7f, drive_amp_q);
    dev_wr(`HPM_REG_RTP, 8'hff);
    repeat (60) @(posedge sys_clk);
    chk("amp_hold", 8'hff, drive_amp_q);
    dev_rd(`HPM_REG_RTP, 8'hff);
    // Standby set through a non-playback mode value
    dev_wr(`HPM_REG_MODE, 8'h46);
    chk("stby_lp", 1'b1, low_power_q);
    chk("stby_amp", 8'h00, drive_amp_q);
    dev_wr(`HPM_REG_MODE, 8'h05);
    chk("wake", 1'b0, low_power_q);
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0000, 2'b00);
    repeat (10) @(posedge sys_clk);
    chk("en_low_lp", 1'b1, low_power_q);
    axi_wr(`HPM_HREG_DUTY, 32'h0000_0064, 2'b00);
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0003, 2'b00);
    dev_wr(`HPM_REG_CTL3, 8'h00);
    dev_wr(`HPM_REG_MODE, 8'h03);
    repeat (3 * `HPM_PWM_PERIOD) @(posedge sys_clk);
    chk("pwm_amp", 8'h64, drive_amp_q);
    axi_wr(`HPM_HREG_ANALOG, 32'h0000_009c, 2'b00);
    dev_wr(`HPM_REG_CTL3, 8'h02);
    repeat (300) @(posedge sys_clk);
    chk("analog_amp", 8'h9c, drive_amp_q);
    // PWM off so the trigger pin rests low for library modes
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0001, 2'b00);
    dev_wr(`HPM_REG_EFFECT, 8'd42);
    chk("index", 7'd42, effect_index_q);
    for (int m = 2; m >= 0; m--) begin
      dev_wr(`HPM_REG_MODE, 8'(m));
      chk("lib_mode", 3'(m), mode_q);
    end
    chk("no_fire", 1'b0, effect_fire_q);
    f0 = fire_cnt;
    dev_wr(`HPM_REG_GO, 8'h01);
    chk("go_fire", f0 + 1, fire_cnt);
    // Edge trigger: PWM rising edges on the trigger pin fire in mode 1
    dev_wr(`HPM_REG_MODE, 8'h01);
    f0 = fire_cnt;
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0003, 2'b00);
    repeat (2 * `HPM_PWM_PERIOD) @(posedge sys_clk);
    axi_wr(`HPM_HREG_CTRL, 32'h0000_0001, 2'b00);
    chk("edge_fire", 32'h0000_0001, 32'(fire_cnt > f0));
    dev_rd(8'h30, 8'h00);
    axi_rd(8'h20, d, 2'b10);
    chk("unmapped_rd", 32'h0000_0000, d);
    axi_wr(8'h20, 32'h0000_0001, 2'b10);
    complete_run();
  end
endmodule // tb_haptic_playback_mode_control

// File: src/hpm_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-wide device registers, 32-bit controller registers
// Notes:   Definitions only
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH
// Device register offsets
`define HPM_REG_MODE       8'h01
`define HPM_REG_RTP        8'h02
`define HPM_REG_EFFECT     8'h04
`define HPM_REG_GO         8'h0c
`define HPM_REG_CTL3       8'h1d
// Mode register fields and values
`define HPM_MODE_LSB       0
`define HPM_MODE_MSB       2
`define HPM_STANDBY_BIT    6
`define HPM_MODE_INT_TRIG  3'h0
`define HPM_MODE_EDGE_TRIG 3'h1
`define HPM_MODE_LVL_TRIG  3'h2
`define HPM_MODE_EXT_IN    3'h3
`define HPM_MODE_REALTIME  3'h5
// Input type field of the third control register, and the go register bit
`define HPM_CTL3_ANALOG_BIT 1
`define HPM_GO_BIT          0
// Device reset values
`define HPM_MODE_RST       8'h40
`define HPM_RTP_RST        8'h00
`define HPM_CTL3_RST       8'h00
`define HPM_EFFECT_RST     8'h01
// Controller register offsets
`define HPM_HREG_CTRL      8'h00
`define HPM_HREG_CMD       8'h04
`define HPM_HREG_STAT      8'h08
`define HPM_HREG_DUTY      8'h0c
`define HPM_HREG_ANALOG    8'h10
// Controller fields
`define HPM_CTRL_EN_BIT    0
`define HPM_CTRL_PWM_BIT   1
`define HPM_CMD_WR_BIT     16
`define HPM_STAT_BUSY_BIT  0
`define HPM_STAT_READY_BIT 1
`define HPM_STAT_SKIP_BIT  2
// Timing
`define HPM_CLK_MHZ        40
`define HPM_POWERUP_US     250
`define HPM_POWERUP_CYC    (`HPM_POWERUP_US * `HPM_CLK_MHZ)
`define HPM_PWM_PERIOD     255
`endif

// File: src/hpm_dev.sv
// Purpose: Driver device end: mode control, playback inputs, library index
// Assumes: Link register port and pins of hpm_link_if; one clock sys_clk
// Notes:   Library engine itself lies outside; only index and fire leave here
`timescale 1ns/100ps
`include "hpm_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module hpm_dev
  import hpm_pkg::*;
#(
  parameter int PWM_PERIOD = `HPM_PWM_PERIOD
) (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  hpm_link_if.dev    lnk,
  output logic [7:0] drive_amp_q,
  output logic       low_power_q,
  output logic [2:0] mode_q,
  output logic [6:0] effect_index_q,
  output logic       effect_fire_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  // Standby is bit 6 of the mode register; low power follows it or a low enable pin
  hpm_byte_t   mode_reg_q;
  hpm_byte_t   rtp_q;
  hpm_byte_t   ctl3_q;
  hpm_byte_t   effect_q;
  logic        go_q;
  logic        ack_q;
  hpm_byte_t   rdata_q;
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic [1:0]  pin_s3_q;
  logic [1:0]  pin_q;
  logic        trig_d_q;
  logic [7:0]  per_cnt_q;
  logic [7:0]  hi_cnt_q;
  logic [7:0]  pwm_amp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Offset match, shared by write decode and read mux
  function automatic logic at_off(input hpm_byte_t addr, input hpm_byte_t off);
    at_off = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire        take      = lnk.reg_req & ~ack_q;
  wire        wr        = take & lnk.reg_we;
  wire        wr_mode   = wr & at_off(lnk.reg_addr, `HPM_REG_MODE);
  wire        wr_rtp    = wr & at_off(lnk.reg_addr, `HPM_REG_RTP);
  wire        wr_ctl3   = wr & at_off(lnk.reg_addr, `HPM_REG_CTL3);
  wire        wr_effect = wr & at_off(lnk.reg_addr, `HPM_REG_EFFECT);
  wire        wr_go     = wr & at_off(lnk.reg_addr, `HPM_REG_GO);
  wire [2:0]  mode      = mode_reg_q[`HPM_MODE_MSB:`HPM_MODE_LSB];
  wire        standby   = mode_reg_q[`HPM_STANDBY_BIT];
  wire        en_lvl    = pin_q[0];
  wire        trig_lvl  = pin_q[1];
  wire        enabled   = en_lvl & ~standby;
  wire        use_analog = ctl3_q[`HPM_CTL3_ANALOG_BIT];
  wire        trig_rise = trig_lvl & ~trig_d_q;
  wire        per_end   = (per_cnt_q == 8'(PWM_PERIOD - 1));
  wire [7:0]  hi_next   = hi_cnt_q + {7'h00, trig_lvl};

  // Library trigger by mode: internal go, pin edge, or pin level
  wire fire_int  = (mode == `HPM_MODE_INT_TRIG) & go_q;
  wire fire_edge = (mode == `HPM_MODE_EDGE_TRIG) & trig_rise;
  wire fire_lvl  = (mode == `HPM_MODE_LVL_TRIG) & trig_lvl;
  wire fire      = enabled & (fire_int | fire_edge | fire_lvl);

  // Amplitude source select
  // Low power forces zero so a stale level never reaches the actuator
  wire [7:0] ext_amp = use_analog ? lnk.analog_lvl : pwm_amp_q;
  wire [7:0] amp_d   = !enabled ? 8'h00 :
                       (mode == `HPM_MODE_REALTIME) ? rtp_q :
                       (mode == `HPM_MODE_EXT_IN)   ? ext_amp :
                       8'h00;

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    at_off(lnk.reg_addr, `HPM_REG_MODE)   ? mode_reg_q :
    at_off(lnk.reg_addr, `HPM_REG_RTP)    ? rtp_q :
    at_off(lnk.reg_addr, `HPM_REG_CTL3)   ? ctl3_q :
    at_off(lnk.reg_addr, `HPM_REG_EFFECT) ? effect_q :
    at_off(lnk.reg_addr, `HPM_REG_GO)     ? {7'h00, go_q} :
    8'h00;

  assign lnk.reg_ack   = ack_q;
  assign lnk.reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port; ack gap blocks a held request from being taken twice
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q   <= take;
      rdata_q <= take ? rd_mux : rdata_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg_q <= `HPM_MODE_RST;
      rtp_q      <= `HPM_RTP_RST;
      ctl3_q     <= `HPM_CTL3_RST;
      effect_q   <= `HPM_EFFECT_RST;
    end else begin
      if (wr_mode) begin
        mode_reg_q <= lnk.reg_wdata;
      end
      if (wr_rtp) begin
        rtp_q <= lnk.reg_wdata;
      end
      if (wr_ctl3) begin
        ctl3_q <= lnk.reg_wdata;
      end
      if (wr_effect) begin
        effect_q <= {1'b0, lnk.reg_wdata[6:0]};
      end
    end
  end

  // Go self-clears once fired; a new write in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      go_q <= 1'b0;
    end else if (wr_go) begin
      go_q <= lnk.reg_wdata[`HPM_GO_BIT];
    end else if (fire_int && enabled) begin
      go_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  // Agreement rejects a one-cycle glitch at the cost of one cycle delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q    <= 2'h0;
      trig_d_q <= 1'b0;
    end else begin
      pin_s1_q <= {lnk.in_pin, lnk.en_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
      trig_d_q <= pin_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PWM duty measure: high samples per period give the amplitude
  // Limitation: a source period other than PWM_PERIOD reads as beating
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      per_cnt_q <= 8'h00;
      hi_cnt_q  <= 8'h00;
      pwm_amp_q <= 8'h00;
    end else if (per_end) begin
      per_cnt_q <= 8'h00;
      hi_cnt_q  <= 8'h00;
      pwm_amp_q <= hi_next;
    end else begin
      per_cnt_q <= per_cnt_q + 8'h01;
      hi_cnt_q  <= hi_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Index mirrors its register one cycle late; zero while in reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      drive_amp_q    <= 8'h00;
      low_power_q    <= 1'b1;
      mode_q         <= 3'h0;
      effect_index_q <= 7'h00;
      effect_fire_q  <= 1'b0;
    end else begin
      drive_amp_q    <= amp_d;
      low_power_q    <= ~enabled;
      mode_q         <= mode;
      effect_index_q <= effect_q[6:0];
      effect_fire_q  <= fire;
    end
  end

endmodule // hpm_dev

// File: src/hpm_host.sv
// Purpose: Playback controller: AXI4-Lite registers to device link and pins
// Assumes: Software issues device register accesses through CMD
// Notes:   Also sources the PWM or analog waveform for external-input mode
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "hpm_cfg.svh"
module hpm_host
  import hpm_pkg::*;
#(
  parameter int READY_CYC  = `HPM_POWERUP_CYC,
  parameter int PWM_PERIOD = `HPM_PWM_PERIOD
) (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  hpm_link_if.host         lnk
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `HPM_HREG_CTRL) | (a == `HPM_HREG_CMD) | (a == `HPM_HREG_STAT) |
             (a == `HPM_HREG_DUTY) | (a == `HPM_HREG_ANALOG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic         aw_hold_q, w_hold_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [1:0]   ctrl_q;
  logic [7:0]   duty_q, analog_q, rd_byte_q, shadow_q, pwm_cnt_q;
  logic [16:0]  cmd_q;
  logic         pend_q, skip_q, ready_q, en_q, req_q, we_q, pwm_q;
  logic [7:0]   addr_q, data_q;
  logic [13:0]  pu_cnt_q;
  hpm_link_st_t st_q;

  wire exec      = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire lane0     = s_axi_wstrb[0];
  wire wr_ctrl   = exec & (awaddr_q == `HPM_HREG_CTRL) & lane0;
  wire wr_cmd    = exec & (awaddr_q == `HPM_HREG_CMD) & ~pend_q;
  wire wr_duty   = exec & (awaddr_q == `HPM_HREG_DUTY) & lane0;
  wire wr_analog = exec & (awaddr_q == `HPM_HREG_ANALOG) & lane0;

  // Mode writes: playback modes clear standby, then skip if nothing changes and standby is clear
  wire       c_we    = cmd_q[`HPM_CMD_WR_BIT];
  wire       c_mode  = c_we & (cmd_q[15:8] == `HPM_REG_MODE);
  wire [2:0] c_modev = cmd_q[`HPM_MODE_MSB:`HPM_MODE_LSB];
  wire       c_play  = (c_modev <= `HPM_MODE_EXT_IN) | (c_modev == `HPM_MODE_REALTIME);
  wire [7:0] c_data  = (c_mode & c_play) ?
                       (cmd_q[7:0] & ~(8'h01 << `HPM_STANDBY_BIT)) : cmd_q[7:0];
  wire       c_skip  = c_mode & (c_data == shadow_q) & ~shadow_q[`HPM_STANDBY_BIT];
  wire       start   = (st_q == LK_IDLE) & pend_q & ready_q;

  wire [31:0] rd_mux =
    (s_axi_araddr == `HPM_HREG_CTRL)   ? {30'h0, ctrl_q} :
    (s_axi_araddr == `HPM_HREG_CMD)    ? {15'h0, cmd_q} :
    (s_axi_araddr == `HPM_HREG_STAT)   ? {16'h0, rd_byte_q, 5'h0, skip_q, ready_q, pend_q} :
    (s_axi_araddr == `HPM_HREG_DUTY)   ? {24'h0, duty_q} :
    (s_axi_araddr == `HPM_HREG_ANALOG) ? {24'h0, analog_q} : 32'h0;

  assign lnk.reg_req    = req_q;
  assign lnk.reg_we     = we_q;
  assign lnk.reg_addr   = addr_q;
  assign lnk.reg_wdata  = data_q;
  assign lnk.en_pin     = en_q;
  assign lnk.in_pin     = pwm_q;
  assign lnk.analog_lvl = analog_q;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken apart, answered together
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0; w_hold_q <= 1'b0; awaddr_q <= 8'h00; wdata_q <= 32'h0;
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1; awaddr_q <= s_axi_awaddr; s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1; wdata_q <= s_axi_wdata; s_axi_wready <= 1'b0;
      end
      if (exec) begin
        aw_hold_q <= 1'b0; w_hold_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0; s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_mux;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0; s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers and waveform source
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= 2'h0; duty_q <= 8'h00; analog_q <= 8'h00;
      pwm_cnt_q <= 8'h00; pwm_q <= 1'b0;
    end else begin
      if (wr_ctrl)   ctrl_q   <= wdata_q[1:0];
      if (wr_duty)   duty_q   <= wdata_q[7:0];
      if (wr_analog) analog_q <= wdata_q[7:0];
      pwm_cnt_q <= (pwm_cnt_q == 8'(PWM_PERIOD - 1)) ? 8'h00 : pwm_cnt_q + 8'h01;
      pwm_q     <= ctrl_q[`HPM_CTRL_PWM_BIT] & (pwm_cnt_q < duty_q);
    end
  end

  // Power-up wait before any link traffic
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pu_cnt_q <= 14'h0; ready_q <= 1'b0;
    end else if (!ready_q) begin
      pu_cnt_q <= pu_cnt_q + 14'h1;
      ready_q  <= (pu_cnt_q >= 14'(READY_CYC - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sequencer; a CMD write while busy is dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= LK_IDLE; cmd_q <= 17'h0; pend_q <= 1'b0; skip_q <= 1'b0;
      req_q <= 1'b0; we_q <= 1'b0; addr_q <= 8'h00; data_q <= 8'h00;
      rd_byte_q <= 8'h00; shadow_q <= `HPM_MODE_RST; en_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_q <= wdata_q[`HPM_CTRL_EN_BIT];
      end
      if (wr_cmd) begin
        cmd_q <= wdata_q[16:0]; pend_q <= 1'b1;
      end
      unique case (st_q)
        LK_IDLE: begin
          if (start && c_skip) begin
            pend_q <= 1'b0; skip_q <= 1'b1;
          end else if (start) begin
            req_q <= 1'b1; we_q <= c_we; addr_q <= cmd_q[15:8];
            data_q <= c_data; skip_q <= 1'b0; st_q <= LK_WAIT;
            if (c_mode && c_play) begin
              en_q <= 1'b1;
            end
          end
        end
        LK_WAIT: begin
          if (lnk.reg_ack) begin
            req_q <= 1'b0; pend_q <= 1'b0; st_q <= LK_IDLE;
            if (!we_q) rd_byte_q <= lnk.reg_rdata;
            if (we_q && addr_q == `HPM_REG_MODE) shadow_q <= data_q;
          end
        end
      endcase
    end
  end

endmodule // hpm_host

// File: src/hpm_link_if.sv
// Purpose: Link between the playback controller and the driver device
// Assumes: Both ends run on sys_clk; pins are resynchronised in the device
// Notes:   Register port is a held request with a one-cycle acknowledge
`timescale 1ns/100ps
interface hpm_link_if;
  logic       reg_req;
  logic       reg_we;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_ack;
  logic [7:0] reg_rdata;
  logic       en_pin;
  logic       in_pin;
  logic [7:0] analog_lvl;
  modport host (output reg_req, reg_we, reg_addr, reg_wdata, en_pin, in_pin, analog_lvl,
                input reg_ack, reg_rdata);
  modport dev (input reg_req, reg_we, reg_addr, reg_wdata, en_pin, in_pin, analog_lvl,
               output reg_ack, reg_rdata);
endinterface // hpm_link_if

// File: src/hpm_pkg.sv
// Purpose: Shared types of the haptic playback mode block
// Assumes: Constants come from hpm_cfg.svh
// Notes:   Types only
package hpm_pkg;
  typedef enum logic [1:0] {LK_IDLE, LK_WAIT} hpm_link_st_t;
  typedef logic [7:0] hpm_byte_t;
endpackage
